// [verilog/motor_status_pkg.sv]
// Constants, indices and types shared by the motor status monitor files.
// Assumes all current inputs share one unsigned scale (multiples of nominal).
package motor_status_pkg;

   // ==========================================
   // Widths and depths
   localparam int CUR_W = 16;
   localparam int TS_W = 48;
   localparam int CODE_W = 4;
   localparam int NUM_IND = 8;
   localparam int NUM_CNT = 3;
   localparam int CNT_W = 16;
   localparam int HIST_DEPTH = 12;
   localparam int HIST_AW = 4;
   localparam int REC_W = TS_W + CODE_W + 5 * CUR_W;

   // ==========================================
   // Indication bit positions
   localparam int IND_STOPPED = 0;
   localparam int IND_STARTING = 1;
   localparam int IND_RUNNING = 2;
   localparam int IND_STALLED = 3;
   localparam int IND_MISSING = 4;
   localparam int IND_LOAD_NORMAL = 5;
   localparam int IND_OVERLOAD = 6;
   localparam int IND_HIGH_OC = 7;

   // ==========================================
   // Counter positions
   localparam int CNT_STARTS = 0;
   localparam int CNT_SUCCEEDED = 1;
   localparam int CNT_STOPS = 2;

   // ==========================================
   // Record field positions (LSB of each field)
   localparam int REC_LOAD_LSB = 0;
   localparam int REC_THERM_LSB = CUR_W;
   localparam int REC_L3_LSB = 2 * CUR_W;
   localparam int REC_L2_LSB = 3 * CUR_W;
   localparam int REC_L1_LSB = 4 * CUR_W;
   localparam int REC_CODE_LSB = 5 * CUR_W;
   localparam int REC_TS_LSB = 5 * CUR_W + CODE_W;

   // ==========================================
   // Reset values and history limits
   localparam logic [NUM_IND-1:0] IND_RST = 8'h01;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [HIST_AW-1:0] PTR_RST = 4'h0;
   localparam logic [HIST_AW-1:0] HIST_LAST = 4'hb;
   localparam logic [HIST_AW:0] HIST_FULL = 5'h0c;

   typedef enum logic [1:0]
   {
      ST_STOPPED = 2'b00,
      ST_STARTING = 2'b01,
      ST_RUNNING = 2'b10,
      ST_STALLED = 2'b11
   } motor_state_t;

endpackage

// [verilog/history_mem.sv]
// Twelve-entry record store for the motor status history.
// Assumes one write and one read address per cycle; read data is registered.
`timescale 1ns/1ps
module history_mem
   import motor_status_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_wr_en,
   input wire logic [HIST_AW-1:0] i_wr_addr,
   input wire logic [REC_W-1:0] i_wr_data,
   input wire logic [HIST_AW-1:0] i_rd_addr,
   output logic [REC_W-1:0] o_rd_data
);

   // ==========================================
   // Storage
   // Array left unreset so it can map onto plain RAM
   logic [REC_W-1:0] mem [HIST_DEPTH];
   logic [REC_W-1:0] rd_reg;
   logic [REC_W-1:0] rd_next;

   always_comb
   begin
      rd_next = mem[i_rd_addr];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_wr_en)
      begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rd_reg <= '0;
      end
      else
      begin
         rd_reg <= rd_next;
      end
   end

   assign o_rd_data = rd_reg;

endmodule

// [verilog/motor_status_monitor.sv]
// Motor status monitor: indications, events, counters and record history.
// Assumes samples, thresholds and time stamp come from logic on i_ref_clk.
//
// How it works
// R1: Stopped when current below no-load threshold
// R2: Direct start: stopped to starting above start-detect
// R3: Starting ends when current below max overload
// R4: Running only after starting or stalled, above no-load
// R5: Running drops when current below no-load
// R6: Running to stalled above max overload
// R7: Missing phase: one low, two above locked
// R8: Load normal between no-load and corrected nominal
// R9: Overloading above nominal, not above max overload
// R10: High overcurrent above max locked-rotor threshold
// R11: Event per change, on/off storage selectable
// R12: Every event carries its time stamp
// R13: Three resettable counters: starts, successes, stops
// R14: Keep newest twelve records, oldest overwritten
// R15: Record holds time, event, currents, thermal, load
// R16: Counters step on rising edges, clear command
// R17: Indications update on the sample cycle
`timescale 1ns/1ps
module motor_status_monitor
   import motor_status_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_sample_valid,
   input wire logic [CUR_W-1:0] i_l1_current,
   input wire logic [CUR_W-1:0] i_l2_current,
   input wire logic [CUR_W-1:0] i_l3_current,
   input wire logic [CUR_W-1:0] i_no_load_thr,
   input wire logic [CUR_W-1:0] i_start_detect_thr,
   input wire logic [CUR_W-1:0] i_max_overload_thr,
   input wire logic [CUR_W-1:0] i_min_locked_thr,
   input wire logic [CUR_W-1:0] i_max_locked_thr,
   input wire logic [CUR_W-1:0] i_nominal_corr,
   input wire logic i_direct_online_start_mode,
   input wire logic [TS_W-1:0] i_time_stamp,
   input wire logic [CUR_W-1:0] i_thermal_delta,
   input wire logic [CUR_W-1:0] i_motor_load,
   input wire logic [NUM_IND-1:0] i_event_on_sel,
   input wire logic [NUM_IND-1:0] i_event_off_sel,
   input wire logic i_counter_clear,
   input wire logic [HIST_AW-1:0] i_hist_rd_age,
   output logic o_motor_stopped,
   output logic o_motor_starting,
   output logic o_motor_running,
   output logic o_motor_stalled,
   output logic o_missing_phase,
   output logic o_load_normal,
   output logic o_overloading,
   output logic o_high_overcurrent,
   output logic o_event_valid,
   output logic o_event_store,
   output logic [CODE_W-1:0] o_event_code,
   output logic [TS_W-1:0] o_event_time,
   output logic [CNT_W-1:0] o_start_count,
   output logic [CNT_W-1:0] o_success_count,
   output logic [CNT_W-1:0] o_stop_count,
   output logic [HIST_AW:0] o_hist_count,
   output logic [REC_W-1:0] o_hist_rd_data
);

   // ==========================================
   // Current comparisons
   logic [CUR_W-1:0] phase [3];
   logic [2:0] ph_low;
   logic [2:0] ph_high;
   logic [CUR_W-1:0] meas_cur;
   logic [CUR_W-1:0] max_l12;
   logic below_no_load;
   logic above_start;
   logic above_max_ovl;
   logic missing_now;

   assign phase[0] = i_l1_current;
   assign phase[1] = i_l2_current;
   assign phase[2] = i_l3_current;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_phase
         assign ph_low[g] = phase[g] < i_no_load_thr;
         assign ph_high[g] = phase[g] > i_min_locked_thr;
      end
   endgenerate

   // Largest phase stands for the motor current
   assign max_l12 = (i_l2_current > i_l1_current) ? i_l2_current : i_l1_current;
   assign meas_cur = (i_l3_current > max_l12) ? i_l3_current : max_l12;

   assign below_no_load = meas_cur < i_no_load_thr;
   assign above_max_ovl = meas_cur > i_max_overload_thr;
   // Without direct start, any current at or above no-load counts as a start
   assign above_start = i_direct_online_start_mode ? (meas_cur > i_start_detect_thr)
                                                   : !below_no_load; // R2
   assign missing_now = (ph_low[0] && ph_high[1] && ph_high[2]) ||
                        (ph_low[1] && ph_high[0] && ph_high[2]) ||
                        (ph_low[2] && ph_high[0] && ph_high[1]); // R7

   // ==========================================
   // State and indications
   motor_state_t state_reg;
   motor_state_t state_next;
   logic [NUM_IND-1:0] ind_reg;
   logic [NUM_IND-1:0] ind_next;

   always_comb
   begin
      state_next = state_reg;
      ind_next = ind_reg;
      if (i_sample_valid) // R17
      begin
         case (state_reg)
            ST_STOPPED: state_next = above_start ? ST_STARTING : ST_STOPPED; // R2
            ST_STARTING:
               state_next = (meas_cur < i_max_overload_thr) ? ST_RUNNING : ST_STARTING; // R3 R4
            ST_RUNNING: state_next = above_max_ovl ? ST_STALLED : ST_RUNNING; // R6
            ST_STALLED: state_next = above_max_ovl ? ST_STALLED : ST_RUNNING;
            default:
               state_next = ST_STOPPED;
         endcase
         if (below_no_load)
         begin
            state_next = ST_STOPPED; // R1 R5
         end
         ind_next[IND_STOPPED] = state_next == ST_STOPPED; // R1
         ind_next[IND_STARTING] = state_next == ST_STARTING; // R2 R3
         ind_next[IND_RUNNING] = state_next == ST_RUNNING; // R4 R5
         ind_next[IND_STALLED] = state_next == ST_STALLED; // R6
         ind_next[IND_MISSING] = missing_now; // R7
         ind_next[IND_LOAD_NORMAL] = (meas_cur > i_no_load_thr) &&
                                     (meas_cur < i_nominal_corr); // R8
         ind_next[IND_OVERLOAD] = (meas_cur > i_nominal_corr) && !above_max_ovl; // R9
         ind_next[IND_HIGH_OC] = meas_cur > i_max_locked_thr; // R10
      end
   end

   // ==========================================
   // Events
   // Several indications may flip on one sample; they queue as pending bits
   // and leave one per cycle, lowest bit first
   logic [NUM_IND-1:0] pend_reg;
   logic [NUM_IND-1:0] pend_next;
   logic [NUM_IND-1:0] emit_mask;
   logic [2:0] emit_idx;
   logic emit_any;
   logic emit_store;
   logic ev_valid_reg;
   logic ev_store_reg;
   logic [CODE_W-1:0] ev_code_reg;
   logic [CODE_W-1:0] ev_code_next;
   logic [TS_W-1:0] ev_time_reg;

   always_comb
   begin
      emit_any = 1'b0;
      emit_idx = 3'h0;
      for (int k = NUM_IND - 1; k >= 0; k--)
      begin
         if (pend_reg[k])
         begin
            emit_any = 1'b1;
            emit_idx = k[2:0];
         end
      end
      emit_mask = '0;
      emit_mask[emit_idx] = emit_any;
      // Set wins: a fresh change is never lost by the clear of its bit
      pend_next = (pend_reg & ~emit_mask) | (ind_next ^ ind_reg); // R11
      emit_store = emit_any && (ind_reg[emit_idx] ? i_event_on_sel[emit_idx]
                                                  : i_event_off_sel[emit_idx]); // R11
      ev_code_next = {ind_reg[emit_idx], emit_idx};
   end

   // ==========================================
   // Counters
   logic [CNT_W-1:0] cnt_reg [NUM_CNT];
   logic [CNT_W-1:0] cnt_next [NUM_CNT];
   logic [NUM_CNT-1:0] cnt_inc;

   always_comb
   begin
      cnt_inc[CNT_STARTS] = ind_next[IND_STARTING] && !ind_reg[IND_STARTING]; // R16
      cnt_inc[CNT_SUCCEEDED] = ind_next[IND_RUNNING] && state_reg == ST_STARTING; // R16
      cnt_inc[CNT_STOPS] = ind_next[IND_STOPPED] && !ind_reg[IND_STOPPED]; // R16
      for (int j = 0; j < NUM_CNT; j++)
      begin
         // Clear then add, so an edge in the clear cycle still counts
         cnt_next[j] = (i_counter_clear ? CNT_RST : cnt_reg[j]) + CNT_W'(cnt_inc[j]); // R13
      end
   end

   // ==========================================
   // History
   logic [HIST_AW-1:0] wr_ptr_reg;
   logic [HIST_AW-1:0] wr_ptr_next;
   logic [HIST_AW:0] hist_cnt_reg;
   logic [HIST_AW:0] hist_cnt_next;
   logic [HIST_AW:0] rd_sum;
   logic [HIST_AW-1:0] rd_addr;
   logic [REC_W-1:0] rec_data;

   always_comb
   begin
      wr_ptr_next = wr_ptr_reg;
      hist_cnt_next = hist_cnt_reg;
      if (emit_store)
      begin
         wr_ptr_next = (wr_ptr_reg == HIST_LAST) ? PTR_RST : wr_ptr_reg + 4'h1; // R14
         hist_cnt_next = hist_cnt_reg + 5'(hist_cnt_reg != HIST_FULL);
      end
      // Age 0 is the newest record
      rd_sum = {1'b0, wr_ptr_reg} + HIST_FULL - 5'h01 - {1'b0, i_hist_rd_age};
      rd_sum = (rd_sum >= HIST_FULL) ? rd_sum - HIST_FULL : rd_sum;
      rd_addr = rd_sum[HIST_AW-1:0];
   end

   assign rec_data = {i_time_stamp, ev_code_next, i_l1_current, i_l2_current,
                      i_l3_current, i_thermal_delta, i_motor_load}; // R15

   history_mem u_history_mem
   (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_wr_en(emit_store),
      .i_wr_addr(wr_ptr_reg),
      .i_wr_data(rec_data),
      .i_rd_addr(rd_addr),
      .o_rd_data(o_hist_rd_data)
   );

   // ==========================================
   // Registers
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_reg <= ST_STOPPED;
         ind_reg <= IND_RST;
         pend_reg <= '0;
         ev_valid_reg <= 1'b0;
         ev_store_reg <= 1'b0;
         ev_code_reg <= '0;
         ev_time_reg <= '0;
         cnt_reg <= '{default: CNT_RST};
         wr_ptr_reg <= PTR_RST;
         hist_cnt_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         ind_reg <= ind_next;
         pend_reg <= pend_next;
         ev_valid_reg <= emit_any;
         ev_store_reg <= emit_store;
         ev_code_reg <= ev_code_next;
         ev_time_reg <= i_time_stamp; // R12
         cnt_reg <= cnt_next;
         wr_ptr_reg <= wr_ptr_next;
         hist_cnt_reg <= hist_cnt_next;
      end
   end

   assign o_motor_stopped = ind_reg[IND_STOPPED];
   assign o_motor_starting = ind_reg[IND_STARTING];
   assign o_motor_running = ind_reg[IND_RUNNING];
   assign o_motor_stalled = ind_reg[IND_STALLED];
   assign o_missing_phase = ind_reg[IND_MISSING];
   assign o_load_normal = ind_reg[IND_LOAD_NORMAL];
   assign o_overloading = ind_reg[IND_OVERLOAD];
   assign o_high_overcurrent = ind_reg[IND_HIGH_OC];
   assign o_event_valid = ev_valid_reg;
   assign o_event_store = ev_store_reg;
   assign o_event_code = ev_code_reg;
   assign o_event_time = ev_time_reg;
   assign o_start_count = cnt_reg[CNT_STARTS];
   assign o_success_count = cnt_reg[CNT_SUCCEEDED];
   assign o_stop_count = cnt_reg[CNT_STOPS];
   assign o_hist_count = hist_cnt_reg;

   // ==========================================
   // Assertions
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_low_sample;
      i_sample_valid && below_no_load;
   endsequence
   sequence s_ind_change;
      ind_reg != $past(ind_reg);
   endsequence
   sequence s_emit_soon;
      ##[1:9] o_event_valid;
   endsequence

   a_stop_low_cur: assert property (s_low_sample |=> o_motor_stopped && !o_motor_running) // R1
      else $error("stopped not shown after low current sample");
   a_start_detect: assert property (i_sample_valid && state_reg == ST_STOPPED &&
      i_direct_online_start_mode && !below_no_load && meas_cur > i_start_detect_thr
      |=> o_motor_starting) // R2
      else $error("start not detected");
   a_start_end: assert property (i_sample_valid && o_motor_starting && !below_no_load &&
      meas_cur < i_max_overload_thr |=> !o_motor_starting && o_motor_running) // R3
      else $error("starting did not end");
   a_run_after_start: assert property ($rose(o_motor_running) |->
      $past(state_reg) == ST_STARTING || $past(state_reg) == ST_STALLED) // R4
      else $error("running without prior start");
   a_run_drop: assert property (o_motor_running ##1 s_low_sample |=> !o_motor_running) // R5
      else $error("running held below no-load");
   a_stall_detect: assert property (i_sample_valid && o_motor_running && above_max_ovl
      |=> o_motor_stalled) // R6
      else $error("stall not detected");
   a_missing_phase: assert property (i_sample_valid |=> o_missing_phase == $past(missing_now)) // R7
      else $error("missing phase mismatch");
   a_load_bands: assert property (i_sample_valid |=> !(o_load_normal && o_overloading)) // R8 R9
      else $error("load normal and overloading together");
   a_high_oc: assert property (i_sample_valid && meas_cur > i_max_locked_thr
      |=> o_high_overcurrent) // R10
      else $error("high overcurrent not shown");
   a_event_follow: assert property (s_ind_change |-> s_emit_soon) // R11
      else $error("indication change produced no event");
   a_event_stamp: assert property (o_event_valid |-> o_event_time == $past(i_time_stamp)) // R12
      else $error("event time stamp wrong");
   a_start_count: assert property ($rose(o_motor_starting) && !$past(i_counter_clear)
      |-> o_start_count == CNT_W'($past(o_start_count) + 1)) // R13 R16
      else $error("start counter did not step");
   a_count_clear: assert property (i_counter_clear && !i_sample_valid
      |=> o_start_count == '0 && o_success_count == '0 && o_stop_count == '0) // R16
      else $error("counters not cleared");
   a_hist_depth: assert property (o_hist_count <= HIST_FULL and
      (o_event_store && $past(o_hist_count) != HIST_FULL
       |-> o_hist_count == $past(o_hist_count) + 5'h01)) // R14
      else $error("history count wrong");

endmodule

// [sim/tb.sv]
// Self-checking bench for the motor status monitor: random and corner samples.
// Assumes the monitor's registered outputs settle well before each falling edge.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin mismatches++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb
   import motor_status_pkg::*;
;
   // ==========================================
   // Signals
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_sample_valid = 1'b0;
   logic [CUR_W-1:0] i_l1_current = '0, i_l2_current = '0, i_l3_current = '0;
   logic [CUR_W-1:0] i_no_load_thr = 16'h0064, i_start_detect_thr = 16'h0258;
   logic [CUR_W-1:0] i_max_overload_thr = 16'h01f4, i_min_locked_thr = 16'h012c;
   logic [CUR_W-1:0] i_max_locked_thr = 16'h0320, i_nominal_corr = 16'h00c8;
   logic i_direct_online_start_mode = 1'b1;
   logic [TS_W-1:0] i_time_stamp = '0;
   logic [CUR_W-1:0] i_thermal_delta = '0, i_motor_load = '0;
   logic [NUM_IND-1:0] i_event_on_sel = '0, i_event_off_sel = '0;
   logic i_counter_clear = 1'b0;
   logic [HIST_AW-1:0] i_hist_rd_age = '0;
   wire logic [NUM_IND-1:0] ind;
   logic o_event_valid, o_event_store;
   logic [CODE_W-1:0] o_event_code;
   logic [TS_W-1:0] o_event_time;
   logic [CNT_W-1:0] o_start_count, o_success_count, o_stop_count;
   logic [HIST_AW:0] o_hist_count;
   logic [REC_W-1:0] o_hist_rd_data, rd_exp;
   int mismatches = 0, tests_run = 0, stored = 0;
   int n_start = 0, n_succ = 0, n_stop = 0;
   bit rd_due = 0;
   logic st;
   motor_state_t m_state = ST_STOPPED;
   logic [NUM_IND-1:0] m_ind = IND_RST;
   logic [CODE_W-1:0] got_q[$];
   logic [REC_W-1:0] rec_q[$];

   motor_status_monitor i_motor_status_monitor (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_sample_valid(i_sample_valid), .i_l1_current(i_l1_current),
      .i_l2_current(i_l2_current), .i_l3_current(i_l3_current),
      .i_no_load_thr(i_no_load_thr), .i_start_detect_thr(i_start_detect_thr),
      .i_max_overload_thr(i_max_overload_thr), .i_min_locked_thr(i_min_locked_thr),
      .i_max_locked_thr(i_max_locked_thr), .i_nominal_corr(i_nominal_corr),
      .i_direct_online_start_mode(i_direct_online_start_mode),
      .i_time_stamp(i_time_stamp), .i_thermal_delta(i_thermal_delta),
      .i_motor_load(i_motor_load), .i_event_on_sel(i_event_on_sel),
      .i_event_off_sel(i_event_off_sel), .i_counter_clear(i_counter_clear),
      .i_hist_rd_age(i_hist_rd_age), .o_motor_stopped(ind[0]), .o_motor_starting(ind[1]),
      .o_motor_running(ind[2]), .o_motor_stalled(ind[3]), .o_missing_phase(ind[4]),
      .o_load_normal(ind[5]), .o_overloading(ind[6]), .o_high_overcurrent(ind[7]),
      .o_event_valid(o_event_valid), .o_event_store(o_event_store),
      .o_event_code(o_event_code), .o_event_time(o_event_time),
      .o_start_count(o_start_count), .o_success_count(o_success_count),
      .o_stop_count(o_stop_count), .o_hist_count(o_hist_count),
      .o_hist_rd_data(o_hist_rd_data));

   // ==========================================
   // Clock and watchdog
   initial
   begin
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      mismatches++;
      wrap_up();
   end

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================
   // Expectation functions
   function automatic logic [CUR_W-1:0] max3(logic [CUR_W-1:0] a, b, c);
      logic [CUR_W-1:0] m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   function automatic motor_state_t next_st(motor_state_t s, logic [CUR_W-1:0] mx, logic direct_online_start_mode);
      if (mx < i_no_load_thr) return ST_STOPPED;
      case (s)
         ST_STOPPED: return (direct_online_start_mode ? mx > i_start_detect_thr : 1'b1) ? ST_STARTING : s;
         ST_STARTING: return (mx < i_max_overload_thr) ? ST_RUNNING : s;
         ST_RUNNING: return (mx > i_max_overload_thr) ? ST_STALLED : s;
         default: return (mx <= i_max_overload_thr) ? ST_RUNNING : s;
      endcase
   endfunction

   function automatic logic [NUM_IND-1:0] calc_ind(motor_state_t s, logic [CUR_W-1:0] a, b, c);
      logic [CUR_W-1:0] mx, nl, ml;
      logic [NUM_IND-1:0] v;
      mx = max3(a, b, c);
      nl = i_no_load_thr;
      ml = i_min_locked_thr;
      v = '0;
      v[IND_STOPPED] = (s == ST_STOPPED);
      v[IND_STARTING] = (s == ST_STARTING);
      v[IND_RUNNING] = (s == ST_RUNNING);
      v[IND_STALLED] = (s == ST_STALLED);
      v[IND_MISSING] = (a < nl && b > ml && c > ml) || (b < nl && a > ml && c > ml)
         || (c < nl && a > ml && b > ml);
      v[IND_LOAD_NORMAL] = (mx > nl) && (mx < i_nominal_corr);
      v[IND_OVERLOAD] = (mx > i_nominal_corr) && (mx <= i_max_overload_thr);
      v[IND_HIGH_OC] = (mx > i_max_locked_thr);
      return v;
   endfunction

   // ==========================================
   // Event monitor; inputs only change on sample edges, when no event is pending
   always @(negedge i_ref_clk)
   begin
      if (rd_due)
      begin
         `CHK("record", rd_exp, o_hist_rd_data)
         rd_due = 0;
      end
      if (i_nrst && o_event_valid === 1'b1)
      begin
         got_q.push_back(o_event_code);
         `CHK("event time", i_time_stamp, o_event_time)
         st = o_event_code[3] ? i_event_on_sel[o_event_code[2:0]]
            : i_event_off_sel[o_event_code[2:0]];
         `CHK("event store", st, o_event_store)
         if (st)
         begin
            stored++;
            rd_exp = {i_time_stamp, o_event_code, i_l1_current, i_l2_current, i_l3_current,
               i_thermal_delta, i_motor_load};
            rec_q.push_back(rd_exp);
            rd_due = 1;
            `CHK("hist count", 5'((stored > 12) ? 12 : stored), o_hist_count)
         end
      end
   end

   // ==========================================
   // One sample, then the event window
   task automatic do_sample(input logic [CUR_W-1:0] a, b, c, input logic direct_online_start_mode);
      motor_state_t ns;
      logic [NUM_IND-1:0] old;
      logic [CODE_W-1:0] got_code;
      int i;
      ns = next_st(m_state, max3(a, b, c), direct_online_start_mode);
      if (ns == ST_STARTING && m_state != ST_STARTING) n_start++;
      if (ns == ST_RUNNING && m_state == ST_STARTING) n_succ++;
      if (ns == ST_STOPPED && m_state != ST_STOPPED) n_stop++;
      m_state = ns;
      old = m_ind;
      m_ind = calc_ind(ns, a, b, c);
      i_l1_current = a;
      i_l2_current = b;
      i_l3_current = c;
      i_direct_online_start_mode = direct_online_start_mode;
      i_time_stamp = {16'($urandom), 32'($urandom)};
      i_thermal_delta = 16'($urandom);
      i_motor_load = 16'($urandom);
      i_event_on_sel = 8'($urandom);
      i_event_off_sel = 8'($urandom);
      i_sample_valid = 1'b1;
      @(negedge i_ref_clk);
      i_sample_valid = 1'b0;
      `CHK("indications", m_ind, ind)
      `CHK("starts", 16'(n_start), o_start_count)
      `CHK("successes", 16'(n_succ), o_success_count)
      `CHK("stops", 16'(n_stop), o_stop_count)
      repeat (11) @(negedge i_ref_clk);
      for (i = 0; i < NUM_IND; i++)
         if (old[i] != m_ind[i])
         begin
            got_code = (got_q.size() > 0) ? got_q.pop_front() : 'x;
            `CHK("event code", {m_ind[i], 3'(i)}, got_code)
         end
      `CHK("extra events", 0, got_q.size())
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      logic [CUR_W-1:0] mx, cur[3];
      int k;
      void'($urandom(32'h5a720d22));
      repeat (8) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_nrst = 1'b1;
      @(negedge i_ref_clk);
      `CHK("reset indications", IND_RST, ind)
      `CHK("reset history", 5'h00, o_hist_count)
      // Corner walk: start, run, missing phase, band edges, stall, short circuit, stop
      do_sample(16'h02bc, 16'h0010, 16'h0010, 1'b1);
      do_sample(16'h0190, 16'h0050, 16'h0050, 1'b1);
      do_sample(16'h0032, 16'h015e, 16'h01c2, 1'b1);
      do_sample(16'h0096, 16'h0096, 16'h0096, 1'b1);
      do_sample(16'h00c8, 16'h0000, 16'h0000, 1'b1);
      do_sample(16'h01f4, 16'h01f4, 16'h01f4, 1'b1);
      do_sample(16'h01f5, 16'h0000, 16'h0000, 1'b1);
      do_sample(16'h0384, 16'h0384, 16'h0384, 1'b1);
      do_sample(16'h01f4, 16'h0000, 16'h0000, 1'b1);
      do_sample(16'h0064, 16'h0064, 16'h0064, 1'b1);
      do_sample(16'h0032, 16'h0000, 16'h0000, 1'b1);
      do_sample(16'h0064, 16'h0000, 16'h0000, 1'b0);
      // Counter clear in mid-run
      i_counter_clear = 1'b1;
      @(negedge i_ref_clk);
      i_counter_clear = 1'b0;
      n_start = 0;
      n_succ = 0;
      n_stop = 0;
      `CHK("cleared starts", 16'h0000, o_start_count)
      `CHK("cleared stops", 16'h0000, o_stop_count)
      // Random samples; a stopped motor in direct start never sits between the thresholds
      for (k = 0; k < 40; k++)
      begin
         i_nominal_corr = 16'($urandom_range(120, 480));
         i_max_locked_thr = 16'($urandom_range(520, 950));
         mx = 16'($urandom_range(0, 1000));
         if (m_state == ST_STOPPED && mx >= 16'h0064 && mx <= 16'h0258)
            mx = ($urandom % 2) ? 16'h0032 : 16'h02bc;
         cur[0] = 16'($urandom_range(0, mx));
         cur[1] = 16'($urandom_range(0, mx));
         cur[2] = 16'($urandom_range(0, mx));
         cur[$urandom % 3] = mx;
         do_sample(cur[0], cur[1], cur[2], ($urandom % 4) != 0);
      end
      // Ring contents, newest first
      if (rec_q.size() >= 12)
         for (k = 0; k < 12; k++)
         begin
            i_hist_rd_age = 4'(k);
            repeat (2) @(negedge i_ref_clk);
            `CHK("ring entry", rec_q[rec_q.size() - 1 - k], o_hist_rd_data)
         end
      wrap_up();
   end
endmodule
